// >>> hw/tcf_config_limit.sv
// Configuration register control: conversion sequencing, limit flags and alert pin
// Contract
// - Three-bit rate field at 15:13, resets to 5, sets continuous period
// - Rate applies only in continuous mode, single-shot ignores it
// - Writing single-shot 1 with shutdown 1 starts exactly one conversion
// - After single-shot conversion, return to shutdown, no more conversions
// - Single-shot bit always reads zero
// - Shutdown bit 11: 0 continuous, 1 shutdown with single-shot only
// - Bit 10 reads 1 when result exceeds first high limit
// - Alert mode: bit 9 reads 1 when result below first low limit
// - Mode bit 8 at 0: window compare sets matching flag
// - Alert mode flags stay set until config read clears them
// - Therm mode: set above high, clear only below low
// - Therm mode: first low flag always reads 0
// - Therm mode flags change only at conversion end, reads keep them
// - Polarity bit 7: alert output active low at 0, high at 1
// - Bit 6 reads 1 when result exceeds second high limit
// - Bit 5 set below second low in alert mode, 0 in therm
// - Mode bit 4 selects behaviour of second pair identically
// - Any config write aborts conversion and acts on new bits at once
`timescale 1ns/1ps
`default_nettype none
module tcf_config_limit #(
    parameter int CYC_PER_MS = tcf_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic cfg_rd,
    output logic [15:0] cfg_rdata,
    // Converter side
    input wire logic conv_done,
    input wire logic signed [13:0] temp_result,
    input wire tcf_pkg::tcf_limit_type limit_a,
    input wire tcf_pkg::tcf_limit_type limit_b,
    output logic conv_start,
    output logic conv_abort,
    output logic conv_busy,
    // Pin
    output logic alert_a_out
);
    logic [2:0] conv_rate_sel_r;
    logic shutdown_sel_r;
    logic limit_a_mode_sel_r;
    logic alert_a_polarity_r;
    logic limit_b_mode_sel_r;
    // Divider width never drops to zero when one cycle stands for a millisecond
    localparam int DIV_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
    localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(CYC_PER_MS - 1);
    tcf_pkg::tcf_state_type state_r;
    logic [DIV_W-1:0] ms_div_r;
    logic [13:0] period_cnt_r;
    logic over_limit_a_flag;
    logic under_limit_a_flag;
    logic over_limit_b_flag;
    logic under_limit_b_flag;
    logic done_ok;
    logic ms_tick;
    logic period_end;
    logic wr_cont;
    logic wr_single;
    logic [15:0] rdata_nxt;

    function automatic logic [13:0] period_ms(input logic [2:0] sel);
        int ms;
        case (sel)
            3'h0: ms = tcf_pkg::PERIOD_MS_0;
            3'h1: ms = tcf_pkg::PERIOD_MS_1;
            3'h2: ms = tcf_pkg::PERIOD_MS_2;
            3'h3: ms = tcf_pkg::PERIOD_MS_3;
            3'h4: ms = tcf_pkg::PERIOD_MS_4;
            3'h5: ms = tcf_pkg::PERIOD_MS_5;
            3'h6: ms = tcf_pkg::PERIOD_MS_6;
            default: ms = tcf_pkg::PERIOD_MS_7;
        endcase
        period_ms = 14'(ms);
    endfunction : period_ms

    // A done arriving in the write cycle belongs to the aborted conversion
    assign done_ok = conv_done && !cfg_wr && (state_r != tcf_pkg::ST_IDLE);
    assign wr_cont = cfg_wr && !cfg_wdata[tcf_pkg::SHUTDOWN_BIT];
    assign wr_single = cfg_wr && cfg_wdata[tcf_pkg::SHUTDOWN_BIT] && cfg_wdata[tcf_pkg::ONE_SHOT_BIT];
    assign ms_tick = (ms_div_r == DIV_W'(0));
    assign period_end = ms_tick && (period_cnt_r == 14'h0001);

    // Control fields
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_rate_sel_r <= tcf_pkg::RATE_RESET;
            shutdown_sel_r <= 1'b0;
            limit_a_mode_sel_r <= 1'b0;
            alert_a_polarity_r <= 1'b0;
            limit_b_mode_sel_r <= 1'b0;
        end else if (cfg_wr) begin
            conv_rate_sel_r <= cfg_wdata[tcf_pkg::RATE_LSB +: 3];
            shutdown_sel_r <= cfg_wdata[tcf_pkg::SHUTDOWN_BIT];
            limit_a_mode_sel_r <= cfg_wdata[tcf_pkg::MODE_A_BIT];
            alert_a_polarity_r <= cfg_wdata[tcf_pkg::POL_A_BIT];
            limit_b_mode_sel_r <= cfg_wdata[tcf_pkg::MODE_B_BIT];
        end
    end

    // Conversion mode; any write re-decides it at once
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= tcf_pkg::ST_CONT;
        end else if (wr_cont) begin
            state_r <= tcf_pkg::ST_CONT;
        end else if (wr_single) begin
            state_r <= tcf_pkg::ST_SINGLE;
        end else if (cfg_wr) begin
            state_r <= tcf_pkg::ST_IDLE;
        end else begin
            case (state_r)
                tcf_pkg::ST_CONT: begin
                    state_r <= tcf_pkg::ST_CONT;
                end
                tcf_pkg::ST_SINGLE: begin
                    if (conv_done) begin
                        state_r <= tcf_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= tcf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Millisecond enable; a write restarts it so the first period is whole
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ms_div_r <= DIV_LOAD;
        end else if (cfg_wr || ms_tick) begin
            ms_div_r <= DIV_LOAD;
        end else begin
            ms_div_r <= ms_div_r - DIV_W'(1);
        end
    end

    // Period in milliseconds; reset value is the default rate so conversion runs from reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            period_cnt_r <= 14'(tcf_pkg::PERIOD_MS_5);
        end else if (wr_cont) begin
            period_cnt_r <= period_ms(cfg_wdata[tcf_pkg::RATE_LSB +: 3]);
        end else if (cfg_wr) begin
            period_cnt_r <= 14'h0000;
        end else if ((state_r == tcf_pkg::ST_CONT) && ms_tick) begin
            if (period_end) begin
                period_cnt_r <= period_ms(conv_rate_sel_r);
            end else if (period_cnt_r != 14'h0000) begin
                period_cnt_r <= period_cnt_r - 14'h0001;
            end
        end
    end

    // Start pulse: a write into an active mode, or the end of a period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_start <= 1'b1;
        end else if (cfg_wr) begin
            conv_start <= wr_cont || wr_single;
        end else begin
            conv_start <= (state_r == tcf_pkg::ST_CONT) && period_end;
        end
    end

    // Abort only what is actually running
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_abort <= 1'b0;
        end else begin
            conv_abort <= cfg_wr && (state_r != tcf_pkg::ST_IDLE);
        end
    end

    // Busy covers the whole active conversion mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_busy <= 1'b0;
        end else begin
            conv_busy <= (state_r != tcf_pkg::ST_IDLE);
        end
    end

    // Alert-mode read clears; therm mode ignores the read inside the comparator
    tcf_limit_cmp u_cmp_a (
        .clock(clock),
        .rstn(rstn),
        .mode_therm(limit_a_mode_sel_r),
        .rd_clear(cfg_rd),
        .done(done_ok),
        .temp(temp_result),
        .limits(limit_a),
        .over_flag(over_limit_a_flag),
        .under_flag(under_limit_a_flag)
    );

    tcf_limit_cmp u_cmp_b (
        .clock(clock),
        .rstn(rstn),
        .mode_therm(limit_b_mode_sel_r),
        .rd_clear(cfg_rd),
        .done(done_ok),
        .temp(temp_result),
        .limits(limit_b),
        .over_flag(over_limit_b_flag),
        .under_flag(under_limit_b_flag)
    );

    // Snapshot taken before a read clear lands, so the host still sees the event
    always_comb begin
        rdata_nxt = 16'h0000;
        rdata_nxt[tcf_pkg::RATE_LSB +: 3] = conv_rate_sel_r;
        rdata_nxt[tcf_pkg::ONE_SHOT_BIT] = 1'b0;
        rdata_nxt[tcf_pkg::SHUTDOWN_BIT] = shutdown_sel_r;
        rdata_nxt[tcf_pkg::OVER_A_BIT] = over_limit_a_flag;
        rdata_nxt[tcf_pkg::UNDER_A_BIT] = under_limit_a_flag;
        rdata_nxt[tcf_pkg::MODE_A_BIT] = limit_a_mode_sel_r;
        rdata_nxt[tcf_pkg::POL_A_BIT] = alert_a_polarity_r;
        rdata_nxt[tcf_pkg::OVER_B_BIT] = over_limit_b_flag;
        rdata_nxt[tcf_pkg::UNDER_B_BIT] = under_limit_b_flag;
        rdata_nxt[tcf_pkg::MODE_B_BIT] = limit_b_mode_sel_r;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= tcf_pkg::CFG_RESET;
        end else begin
            cfg_rdata <= rdata_nxt;
        end
    end

    // Reset drives the inactive level of active-low polarity
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            alert_a_out <= 1'b1;
        end else begin
            alert_a_out <= (over_limit_a_flag | under_limit_a_flag) ~^ alert_a_polarity_r;
        end
    end
endmodule : tcf_config_limit
`default_nettype wire

// >>> inc/tcf_pkg.sv
// Package with register layout, rates and carrier types for the config/limit block
package tcf_pkg;
    localparam int CLK_HZ = 10000000;
    localparam logic [15:0] CFG_RESET = 16'ha000;
    localparam int RATE_LSB = 13;
    localparam int ONE_SHOT_BIT = 12;
    localparam int SHUTDOWN_BIT = 11;
    localparam int OVER_A_BIT = 10;
    localparam int UNDER_A_BIT = 9;
    localparam int MODE_A_BIT = 8;
    localparam int POL_A_BIT = 7;
    localparam int OVER_B_BIT = 6;
    localparam int UNDER_B_BIT = 5;
    localparam int MODE_B_BIT = 4;
    localparam logic [2:0] RATE_RESET = 3'h5;
    // Conversion periods in milliseconds, indexed by rate select
    localparam int PERIOD_MS_0 = 15;
    localparam int PERIOD_MS_1 = 50;
    localparam int PERIOD_MS_2 = 100;
    localparam int PERIOD_MS_3 = 250;
    localparam int PERIOD_MS_4 = 500;
    localparam int PERIOD_MS_5 = 1000;
    localparam int PERIOD_MS_6 = 4000;
    localparam int PERIOD_MS_7 = 16000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    typedef struct packed {
        logic signed [13:0] high;
        logic signed [13:0] low;
    } tcf_limit_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONT = 2'b01,
        ST_SINGLE = 2'b10
    } tcf_state_type;
endpackage : tcf_pkg

// >>> hw/tcf_limit_cmp.sv
// One limit comparator pair with alert-window and therm-hysteresis modes
`timescale 1ns/1ps
`default_nettype none
module tcf_limit_cmp (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Controls
    input wire logic mode_therm,
    input wire logic rd_clear,
    input wire logic done,
    input wire logic signed [13:0] temp,
    input wire tcf_pkg::tcf_limit_type limits,
    // Flags
    output logic over_flag,
    output logic under_flag
);
    logic over_r;
    logic under_r;
    logic over_nxt;
    logic under_nxt;

    always_comb begin
        over_nxt = over_r;
        under_nxt = under_r;
        if (mode_therm) begin
            under_nxt = 1'b0;
            if (done && temp > limits.high) begin
                over_nxt = 1'b1;
            end else if (done && temp < limits.low) begin
                over_nxt = 1'b0;
            end
        end else begin
            // Read clears first so an event in the same cycle wins
            if (rd_clear) begin
                over_nxt = 1'b0;
                under_nxt = 1'b0;
            end
            if (done && temp > limits.high) begin
                over_nxt = 1'b1;
            end
            if (done && temp < limits.low) begin
                under_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            over_r <= 1'b0;
            under_r <= 1'b0;
        end else begin
            over_r <= over_nxt;
            under_r <= under_nxt;
        end
    end

    assign over_flag = over_r;
    assign under_flag = under_r;
endmodule : tcf_limit_cmp
`default_nettype wire

// >>> testbench/tcf_config_limit_monitor.sv
// Port checker for the config/limit block
`timescale 1ns/1ps
`default_nettype none
module tcf_config_limit_monitor #(
    parameter int CYC_PER_MS = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Watched ports
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic cfg_rd,
    input wire logic [15:0] cfg_rdata,
    input wire logic conv_done,
    input wire logic signed [13:0] temp_result,
    input wire tcf_pkg::tcf_limit_type limit_a,
    input wire logic conv_start,
    input wire logic conv_busy,
    input wire logic alert_a_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_SS_ZERO: assert property (cfg_rdata[12] == 1'b0)
        else $error("trigger bit read as one");
    AST_WR_FIELDS: assert property (cfg_wr |-> ##2
        (cfg_rdata & 16'he990) == ($past(cfg_wdata, 2) & 16'he990)) else $error("field lost");
    AST_ONE_START: assert property (cfg_wr && cfg_wdata[12] && cfg_wdata[11] |=>
        conv_start) else $error("no single start");
    AST_SINGLE_END: assert property (cfg_rdata[11] && conv_busy && conv_done && !cfg_wr && !$past(cfg_wr) |->
        ##2 !conv_busy) else $error("still busy after single");
    AST_THERM_UNDER: assert property (cfg_rdata[8] && $past(cfg_rdata[8]) |->
        !cfg_rdata[9]) else $error("low flag in therm mode");
    AST_ALERT_PIN: assert property ($stable(cfg_rdata[10:7]) |->
        alert_a_out == ((cfg_rdata[10] | cfg_rdata[9]) ~^ cfg_rdata[7])) else $error("alert pin");
    AST_READ_CLEAR: assert property (cfg_rd && !cfg_rdata[8] && !conv_done ##1 !conv_done |=>
        cfg_rdata[10:9] == 2'h0) else $error("read did not clear");
    AST_OVER_SET: assert property (conv_done && conv_busy && !cfg_wr &&
        temp_result > limit_a.high |-> ##2 cfg_rdata[10]) else $error("high flag not set");
endmodule : tcf_config_limit_monitor
bind tcf_config_limit tcf_config_limit_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
    .clock(clock),
    .rstn(rstn),
    .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata),
    .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata),
    .conv_done(conv_done),
    .temp_result(temp_result),
    .limit_a(limit_a),
    .conv_start(conv_start),
    .conv_busy(conv_busy),
    .alert_a_out(alert_a_out)
);
`default_nettype wire

// >>> testbench/tcf_conv_model.sv
// Converter model: one done pulse a fixed time after each start
`timescale 1ns/1ps
`default_nettype none
module tcf_conv_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Converter handshake
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic signed [13:0] temp_set,
    output logic conv_done,
    output logic signed [13:0] temp_result
);
    localparam int LAT = 5;
    int cnt;
    // Start wins: a write aborts and restarts in the same cycle
    always_ff @(posedge clock or negedge rstn)
        cnt <= !rstn ? 0 : conv_start ? LAT : (conv_abort || cnt == 0) ? 0 : cnt - 1;
    assign conv_done = (cnt == 1);
    // Inverse outside done, so a stale sample never matches
    assign temp_result = conv_done ? temp_set : ~temp_set;
endmodule : tcf_conv_model
`default_nettype wire

// >>> testbench/tb_tcf_config_limit.sv
// Bench for the config/limit block with converter model
`timescale 1ns/1ps
`default_nettype none
module tb_tcf_config_limit;
    logic clock = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000, cfg_rdata;
    logic conv_done, conv_start, conv_abort, conv_busy, alert_a_out;
    logic signed [13:0] temp_result, temp_set = 14'sh0000;
    tcf_pkg::tcf_limit_type limit_a = {14'sh0064, 14'sh3f9c}, limit_b = {14'sh0032, 14'sh3fce};
    int n_errors = 0, checks_done = 0;
    int periods [8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};
    always #50 clock = ~clock;
    // One cycle per ms keeps the slowest rate short
    tcf_config_limit #(.CYC_PER_MS(1)) u_dut (
        .clock(clock),
        .rstn(rstn),
        .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata),
        .cfg_rd(cfg_rd),
        .cfg_rdata(cfg_rdata),
        .conv_done(conv_done),
        .temp_result(temp_result),
        .limit_a(limit_a),
        .limit_b(limit_b),
        .conv_start(conv_start),
        .conv_abort(conv_abort),
        .conv_busy(conv_busy),
        .alert_a_out(alert_a_out)
    );
    tcf_conv_model u_conv (
        .clock(clock),
        .rstn(rstn),
        .conv_start(conv_start),
        .conv_abort(conv_abort),
        .temp_set(temp_set),
        .conv_done(conv_done),
        .temp_result(temp_result)
    );
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic acc(input logic w, input logic [15:0] d);
        @(posedge clock);
        {cfg_wr, cfg_rd} <= {w, !w};
        cfg_wdata <= d;
        #10;
        if (!w) cmp(cfg_rdata, d);
        @(posedge clock);
        {cfg_wr, cfg_rd} <= 2'b00;
        #1;
    endtask : acc
    task automatic shot(input logic [15:0] cfg, input logic signed [13:0] t, input logic s);
        int n = 0;
        temp_set <= t;
        acc(1'b1, cfg);
        cmp(16'(conv_start), 16'(s));
        // Let the start pulse of this write pass before counting further starts
        @(posedge clock);
        repeat (40) @(negedge clock) n += int'(conv_start);
        cmp(16'(n), 16'h0000);
    endtask : shot
    task automatic t_rates;
        int n;
        acc(1'b0, tcf_pkg::CFG_RESET);
        for (int r = 0; r < 8; r++) begin
            acc(1'b1, 16'(r << 13));
            cmp(16'({conv_start, conv_abort}), 16'h0003);
            n = 0;
            @(negedge clock);
            do @(negedge clock) n++; while (conv_start !== 1'b1 && n < 20000);
            cmp(16'(n), 16'(periods[r]));
        end
        shot(16'h0800, 14'sh0000, 1'b0);
    endtask : t_rates
    task automatic t_alert;
        shot(16'h1800, 14'sh00c8, 1'b1);
        cmp(16'(alert_a_out), 16'h0000);
        acc(1'b0, 16'h0c40);
        acc(1'b0, 16'h0800);
        shot(16'h1800, 14'sh3f38, 1'b1);
        acc(1'b0, 16'h0a20);
        shot(16'h1880, 14'sh00c8, 1'b1);
        cmp(16'(alert_a_out), 16'h0001);
        acc(1'b0, 16'h0cc0);
    endtask : t_alert
    task automatic t_therm;
        shot(16'h1910, 14'sh00c8, 1'b1);
        acc(1'b0, 16'h0d50);
        acc(1'b0, 16'h0d50);
        shot(16'h1910, 14'sh0000, 1'b1);
        acc(1'b0, 16'h0d50);
        shot(16'h1910, 14'sh3f38, 1'b1);
        acc(1'b0, 16'h0910);
    endtask : t_therm
    task automatic test_done;
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        #4000000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        t_rates();
        t_alert();
        t_therm();
        test_done();
    end
endmodule : tb_tcf_config_limit
`default_nettype wire
